// [core/tx_link_admin_pkg.sv]
// Constants and carrier types for the transmit link administration registers
package tx_link_admin_pkg;
	localparam int ADDR_W = 16;
	localparam int IDX_W = 14;
	localparam logic [13:0] IDX_ADD_LINK = 14'h0333;
	localparam logic [13:0] IDX_LINK_ID0 = 14'h0336;
	localparam logic [13:0] IDX_LINK_ID7 = 14'h033D;
	localparam logic [13:0] IDX_ACTIVE = 14'h0345;
	localparam logic [13:0] IDX_MODE = 14'h0346;
	localparam logic [13:0] IDX_GRP_CNT = 14'h0401;
	localparam logic [13:0] IDX_LNK_CNT = 14'h0402;
	localparam logic [13:0] IDX_INTEG0 = 14'h0403;
	localparam logic [13:0] IDX_INTEG3 = 14'h0406;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_ACTIVE = 16'h0000;
	localparam logic [15:0] RST_MODE = 16'hFFFF;
	localparam logic [15:0] RST_INTEG = 16'h0C0C;
	localparam logic [15:0] MASK_LINK_ID = 16'h1F1F;
	localparam logic [15:0] MASK_INTEG = 16'h0FFF;
	localparam logic [15:0] MASK_GRP_CNT = 16'h00FF;
	localparam int ADD_EN_BIT = 3;
	localparam int ADD_GRP_LSB = 0;
	localparam int ID_LO_LSB = 0;
	localparam int ID_HI_LSB = 8;
	localparam int ID_W = 5;
	localparam int INTEG_LO_LSB = 0;
	localparam int INTEG_HI_LSB = 8;
	localparam int CODE_W = 4;
	localparam int EXP_W = 5;
	localparam logic [4:0] PERIOD_BASE_EXP = 5'h08;
	localparam logic [3:0] CODE_RESERVED = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [13:0] idx;
		logic [15:0] data;
		logic [1:0] strb;
	} reg_wr_t;
endpackage : tx_link_admin_pkg

// [core/period_code_decode.sv]
// Integration period code to cycle-count exponent for one group
`timescale 1ns/1ps
`default_nettype none
module period_code_decode (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_present,
	input wire logic [tx_link_admin_pkg::CODE_W-1:0] i_code,
	output logic [tx_link_admin_pkg::EXP_W-1:0] o_exp
);
	// Reserved code keeps the last good period rather than inventing one
	wire logic code_ok = (i_code != tx_link_admin_pkg::CODE_RESERVED);
	wire logic [tx_link_admin_pkg::EXP_W-1:0] nxt_exp = !i_present ? '0 :
		code_ok ? tx_link_admin_pkg::PERIOD_BASE_EXP + {1'b0, i_code} : o_exp;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) o_exp <= '0;
		else o_exp <= nxt_exp;
	end
endmodule : period_code_decode
`default_nettype wire

// [core/reg_axil_port.sv]
// AXI4-Lite slave handshake for the 16-bit register bank
`timescale 1ns/1ps
`default_nettype none
module reg_axil_port (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [tx_link_admin_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [15:0] i_rd_data,
	input wire logic i_rd_ok,
	input wire logic i_wr_ok,
	output tx_link_admin_pkg::reg_wr_t o_wr,
	output logic o_wr_en
);
	logic aw_ff, w_ff;
	logic [13:0] idx_ff;
	logic [15:0] data_ff;
	logic [1:0] strb_ff;
	wire logic aw_take = i_awvalid && o_awready;
	wire logic w_take = i_wvalid && o_wready;
	wire logic ar_take = i_arvalid && o_arready;
	// Both halves are held so address and data may arrive in either order
	assign o_wr_en = aw_ff && w_ff && !o_bvalid;
	assign o_wr = '{idx: idx_ff, data: data_ff, strb: strb_ff};
	assign o_awready = !aw_ff && !o_bvalid;
	assign o_wready = !w_ff && !o_bvalid;
	assign o_arready = !o_rvalid;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			idx_ff <= '0;
			data_ff <= '0;
			strb_ff <= '0;
			o_bvalid <= 1'b0;
			o_bresp <= tx_link_admin_pkg::RESP_OKAY;
		end else begin
			if (aw_take) idx_ff <= i_awaddr[15:2];
			if (w_take) data_ff <= i_wdata[15:0];
			if (w_take) strb_ff <= i_wstrb[1:0];
			aw_ff <= o_wr_en ? 1'b0 : (aw_ff || aw_take);
			w_ff <= o_wr_en ? 1'b0 : (w_ff || w_take);
			if (o_wr_en) begin
				o_bvalid <= 1'b1;
				o_bresp <= i_wr_ok ? tx_link_admin_pkg::RESP_OKAY : tx_link_admin_pkg::RESP_SLVERR;
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= tx_link_admin_pkg::RESP_OKAY;
		end else if (ar_take) begin
			o_rvalid <= 1'b1;
			o_rdata <= {16'h0000, i_rd_data};
			o_rresp <= i_rd_ok ? tx_link_admin_pkg::RESP_OKAY : tx_link_admin_pkg::RESP_SLVERR;
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule : reg_axil_port
`default_nettype wire

// [core/tx_link_admin_regs.sv]
// Transmit link administration register bank with AXI4-Lite access
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tx_link_admin_regs #(
	parameter int NUM_GROUPS = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [15:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [15:0] i_link_group_mode,
	input wire logic [15:0] i_link_started,
	output logic o_add_link_req,
	output logic [2:0] o_add_link_group,
	output logic [15:0][4:0] o_link_id,
	output logic [15:0] o_link_count_user,
	output logic [7:0] o_group_count_user,
	output logic [7:0][4:0] o_integ_exp
);
	////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] GRP_PRESENT = 8'((1 << NUM_GROUPS) - 1);
	tx_link_admin_pkg::reg_wr_t wr;
	logic wr_en;
	logic [3:0] add_ctl_ff;
	logic [7:0][12:0] link_id_ff;
	logic [3:0][11:0] integ_ff;
	logic [7:0] grp_cnt_ff;
	logic [15:0] lnk_cnt_ff;
	logic [15:0] active_ff;
	logic [15:0] mode_ff;
	// Answers from the decodes below, declared ahead of the port that uses them
	logic [15:0] rd_data;
	logic rd_ok;
	logic wr_ok;

	reg_axil_port u_port (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.i_rd_data(rd_data),
		.i_rd_ok(rd_ok),
		.i_wr_ok(wr_ok),
		.o_wr(wr),
		.o_wr_en(wr_en)
	);

	////////////////////////////////////////////////////////////////////////////
	// Write decode; unmapped words answer SLVERR and change nothing
	wire logic [15:0] wmask = {{8{wr.strb[1]}}, {8{wr.strb[0]}}};
	wire logic w_add = wr.idx == tx_link_admin_pkg::IDX_ADD_LINK;
	wire logic w_id = wr.idx >= tx_link_admin_pkg::IDX_LINK_ID0 && wr.idx <= tx_link_admin_pkg::IDX_LINK_ID7;
	wire logic w_grp = wr.idx == tx_link_admin_pkg::IDX_GRP_CNT;
	wire logic w_lnk = wr.idx == tx_link_admin_pkg::IDX_LNK_CNT;
	wire logic w_int = wr.idx >= tx_link_admin_pkg::IDX_INTEG0 && wr.idx <= tx_link_admin_pkg::IDX_INTEG3;
	wire logic w_ro = wr.idx == tx_link_admin_pkg::IDX_ACTIVE || wr.idx == tx_link_admin_pkg::IDX_MODE;
	assign wr_ok = w_add || w_id || w_grp || w_lnk || w_int || w_ro;
	wire logic [13:0] w_id_off = wr.idx - tx_link_admin_pkg::IDX_LINK_ID0;
	wire logic [13:0] w_int_off = wr.idx - tx_link_admin_pkg::IDX_INTEG0;
	wire logic [2:0] w_id_sel = w_id_off[2:0];
	wire logic [1:0] w_int_sel = w_int_off[1:0];
	wire logic [15:0] id_old = {3'b000, link_id_ff[w_id_sel]};
	wire logic [15:0] int_old = {4'h0, integ_ff[w_int_sel]};
	wire logic [15:0] id_new = ((id_old & ~wmask) | (wr.data & wmask)) & tx_link_admin_pkg::MASK_LINK_ID;
	wire logic [15:0] int_new = ((int_old & ~wmask) | (wr.data & wmask)) & tx_link_admin_pkg::MASK_INTEG;
	wire logic [15:0] grp_new = (({8'h00, grp_cnt_ff} & ~wmask) | (wr.data & wmask)) & tx_link_admin_pkg::MASK_GRP_CNT;
	wire logic [15:0] lnk_new = (lnk_cnt_ff & ~wmask) | (wr.data & wmask);

	////////////////////////////////////////////////////////////////////////////
	// Read decode on the live address; the port samples it at the handshake
	wire logic [13:0] ridx = i_araddr[15:2];
	wire logic r_add = ridx == tx_link_admin_pkg::IDX_ADD_LINK;
	wire logic r_id = ridx >= tx_link_admin_pkg::IDX_LINK_ID0 && ridx <= tx_link_admin_pkg::IDX_LINK_ID7;
	wire logic r_act = ridx == tx_link_admin_pkg::IDX_ACTIVE;
	wire logic r_mode = ridx == tx_link_admin_pkg::IDX_MODE;
	wire logic r_grp = ridx == tx_link_admin_pkg::IDX_GRP_CNT;
	wire logic r_lnk = ridx == tx_link_admin_pkg::IDX_LNK_CNT;
	wire logic r_int = ridx >= tx_link_admin_pkg::IDX_INTEG0 && ridx <= tx_link_admin_pkg::IDX_INTEG3;
	assign rd_ok = r_add || r_id || r_act || r_mode || r_grp || r_lnk || r_int;
	wire logic [13:0] r_id_off = ridx - tx_link_admin_pkg::IDX_LINK_ID0;
	wire logic [13:0] r_int_off = ridx - tx_link_admin_pkg::IDX_INTEG0;
	wire logic [15:0] rd_id = {3'b000, link_id_ff[r_id_off[2:0]]};
	wire logic [15:0] rd_int = {4'h0, integ_ff[r_int_off[1:0]]};
	// Add-link word reads as all zero, whatever was written
	assign rd_data =
		r_id ? rd_id :
		r_act ? active_ff :
		r_mode ? mode_ff :
		r_grp ? {8'h00, grp_cnt_ff} :
		r_lnk ? lnk_cnt_ff :
		r_int ? rd_int :
		tx_link_admin_pkg::RST_ZERO;

	////////////////////////////////////////////////////////////////////////////
	// Only bit 3 and the group number act; the pattern in 9:4 is not checked
	wire logic add_wr = wr_en && w_add && wr.strb[0];
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) add_ctl_ff <= 4'h0;
		else if (add_wr) add_ctl_ff <= wr.data[3:0];
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link_id_ff <= '0;
			integ_ff <= {4{tx_link_admin_pkg::RST_INTEG[11:0]}};
			grp_cnt_ff <= tx_link_admin_pkg::RST_ZERO[7:0];
			lnk_cnt_ff <= tx_link_admin_pkg::RST_ZERO;
		end else if (wr_en) begin
			if (w_id) link_id_ff[w_id_sel] <= id_new[12:0];
			if (w_int) integ_ff[w_int_sel] <= int_new[11:0];
			if (w_grp) grp_cnt_ff <= grp_new[7:0];
			if (w_lnk) lnk_cnt_ff <= lnk_new;
		end
	end

	// Status follows the transmit engine each cycle; bus writes never reach it
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			active_ff <= tx_link_admin_pkg::RST_ACTIVE;
			mode_ff <= tx_link_admin_pkg::RST_MODE;
		end else begin
			active_ff <= i_link_group_mode & i_link_started;
			mode_ff <= ~i_link_group_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control outputs
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_add_link_req <= 1'b0;
			o_add_link_group <= 3'h0;
			o_link_count_user <= '0;
			o_group_count_user <= '0;
		end else begin
			o_add_link_req <= add_ctl_ff[tx_link_admin_pkg::ADD_EN_BIT];
			o_add_link_group <= add_ctl_ff[2:0];
			o_link_count_user <= lnk_cnt_ff;
			o_group_count_user <= grp_cnt_ff & GRP_PRESENT;
		end
	end

	genvar k;
	generate
		for (k = 0; k < 16; k++) begin : g_link
			wire logic [4:0] id_k = (k < 8) ? link_id_ff[k % 8][4:0] : link_id_ff[k % 8][12:8];
			// A plain-mode link never sees its identifier
			always_ff @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n) o_link_id[k] <= '0;
				else o_link_id[k] <= i_link_group_mode[k] ? id_k : 5'h00;
			end
		end
		for (k = 0; k < 8; k++) begin : g_grp
			wire logic [3:0] code_k = (k < 4) ? integ_ff[k % 4][3:0] : integ_ff[k % 4][11:8];
			period_code_decode u_dec (
				.i_mclk(i_mclk),
				.i_rst_n(i_rst_n),
				.i_present(GRP_PRESENT[k]),
				.i_code(code_k),
				.o_exp(o_integ_exp[k])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic rd_add_q, rd_int_q, rd_grp_q;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_add_q <= 1'b0;
			rd_int_q <= 1'b0;
			rd_grp_q <= 1'b0;
		end else if (i_arvalid && o_arready) begin
			rd_add_q <= r_add;
			rd_int_q <= r_int;
			rd_grp_q <= r_grp;
		end
	end

	a_add_reads_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_rvalid && rd_add_q |-> o_rdata == 32'h00000000) else $error("add-link read not zero");
	a_add_join_out: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && w_add && wr.strb[0] |-> ##2 o_add_link_req == $past(wr.data[3], 2)) else $error("add request wrong");
	a_id_plain_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!i_link_group_mode[0] |=> o_link_id[0] == 5'h00) else $error("plain link shows id");
	a_active_status: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_link_started[3] && !i_link_group_mode[3] |=> !active_ff[3] && mode_ff[3]) else $error("active without mode");
	a_mode_status: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_link_group_mode == 16'h0000) [*2] |-> mode_ff == 16'hFFFF) else $error("mode status wrong");
	a_grp_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_rvalid && rd_grp_q |-> o_rdata[31:8] == 24'h000000) else $error("group select upper bits");
	a_lnk_cnt_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && w_lnk && wr.strb == 2'b11 |-> ##2 o_link_count_user == $past(wr.data, 2)) else $error("link select lost");
	a_integ_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_rvalid && rd_int_q |-> o_rdata[15:12] == 4'h0) else $error("integration upper bits");
	a_absent_group: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		NUM_GROUPS < 8 |-> o_group_count_user[7] == 1'b0) else $error("absent group active");
	a_ro_write_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && w_ro |=> $stable(lnk_cnt_ff) && $stable(grp_cnt_ff)) else $error("read-only write changed state");
	a_read_answer: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
	a_write_answer: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid) else $error("write answer late");
	a_resp_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_bvalid && !i_bready |=> o_bvalid) else $error("write answer dropped");
	a_read_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
	a_rd_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_rvalid |-> o_rdata[31:16] == 16'h0000) else $error("read upper half not zero");
	a_wr_resp_err: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && !wr_ok |=> o_bresp == tx_link_admin_pkg::RESP_SLVERR) else $error("unmapped write not refused");
	a_wr_resp_okay: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && wr_ok |=> o_bresp == tx_link_admin_pkg::RESP_OKAY) else $error("mapped write refused");
	a_idle_no_change: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!wr_en |=> $stable(add_ctl_ff) && $stable(link_id_ff) && $stable(integ_ff)) else $error("state moved");

	////////////////////////////////////////////////////////////////////////////
	// Status, identifier, add-link group and count-select follow-through
	a_active_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> active_ff == ($past(i_link_group_mode) & $past(i_link_started))) else $error("active stale");
	a_mode_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> mode_ff == ~$past(i_link_group_mode)) else $error("mode status stale");
	a_id_high_map: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_link_group_mode[15] |=> o_link_id[15] == $past(link_id_ff[7][12:8])) else $error("high link id wrong");
	a_id_plain_high: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!i_link_group_mode[15] |=> o_link_id[15] == 5'h00) else $error("plain high link shows id");
	a_id_write_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && w_id |=> link_id_ff[$past(w_id_sel)][7:5] == 3'b000) else $error("id reserved bits kept");
	a_add_group_out: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && w_add && wr.strb[0] |-> ##2 o_add_link_group == $past(wr.data[2:0], 2)) else $error("add group wrong");
	a_grp_cnt_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && w_grp && wr.strb[0] |-> ##2 o_group_count_user == ($past(wr.data[7:0], 2) & GRP_PRESENT))
		else $error("group select lost");
	a_link_cnt_out: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> o_link_count_user == $past(lnk_cnt_ff)) else $error("link select stale");

	////////////////////////////////////////////////////////////////////////////
	// Integration period checks
	a_reserved_code: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		integ_ff[0][3:0] == tx_link_admin_pkg::CODE_RESERVED |=> $stable(o_integ_exp[0]))
		else $error("reserved code moved period");
	a_exp_range: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_integ_exp[0] <= 5'h16) else $error("period exponent out of range");
	a_absent_exp: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!GRP_PRESENT[7] |-> o_integ_exp[7] == 5'h00) else $error("absent group has period");
	a_integ_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		wr_en && w_int && wr.strb == 2'b11 |=> integ_ff[$past(w_int_sel)] == $past(wr.data[11:0]))
		else $error("integration write lost");

	// Main scenarios
	c_add_link: cover property (@(posedge i_mclk) disable iff (!i_rst_n) wr_en && w_add && wr.data[3]);
	c_reserved_code: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
		integ_ff[0][3:0] == tx_link_admin_pkg::CODE_RESERVED);
	c_unmapped_write: cover property (@(posedge i_mclk) disable iff (!i_rst_n) wr_en && !wr_ok);
	c_int_read: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_rvalid && rd_int_q);
	c_link_active: cover property (@(posedge i_mclk) disable iff (!i_rst_n) active_ff != 16'h0000);
endmodule : tx_link_admin_regs
`default_nettype wire

// [bench/tx_link_admin_regs_tb_top.sv]
// Self-checking bench for the transmit link administration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module tx_link_admin_regs_tb_top;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [15:0] awaddr = 16'h0000;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [15:0] araddr = 16'h0000;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [15:0] grp_mode = 16'h0000;
	logic [15:0] started = 16'h0000;
	logic awready, wready, bvalid, arready, rvalid, add_req;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] add_grp;
	logic [15:0][4:0] link_id;
	logic [15:0] lnk_user;
	logic [7:0] grp_user;
	logic [7:0][4:0] integ_exp;
	logic [7:0] grp_user4;
	logic [7:0][4:0] integ_exp4;
	int bad_count = 0;
	int checks = 0;
	tx_link_admin_regs #(.NUM_GROUPS(8)) i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_link_group_mode(grp_mode), .i_link_started(started),
		.o_add_link_req(add_req), .o_add_link_group(add_grp), .o_link_id(link_id),
		.o_link_count_user(lnk_user), .o_group_count_user(grp_user), .o_integ_exp(integ_exp));
	// Smallest variant shares the bus; only its group outputs are watched
	tx_link_admin_regs #(.NUM_GROUPS(4)) i_dut4 (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(), .o_bresp(), .o_bvalid(), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(), .o_rdata(), .o_rresp(), .o_rvalid(),
		.i_rready(rready), .i_link_group_mode(grp_mode), .i_link_started(started),
		.o_add_link_req(), .o_add_link_group(), .o_link_id(),
		.o_link_count_user(), .o_group_count_user(grp_user4), .o_integ_exp(integ_exp4));
	initial begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	// Both halves offered together; each released at its own handshake edge
	task automatic axi_wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] er,
		input logic [3:0] s = 4'hF);
		int n;
		logic aw_p;
		logic w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge i_mclk);
			if (!aw_p && !w_p && bvalid === 1'b1) begin
				`CHK(bresp, er)
				bready <= 1'b0;
				break;
			end
			if (aw_p && awready === 1'b1) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wready === 1'b1) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
		end
		if (n == 60) begin
			bad_count++;
		end
		// One idle edge so the next call never reassigns a strobe in this time step
		@(posedge i_mclk);
	endtask : axi_wr
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] ed, input logic [1:0] er);
		int n;
		logic ar_p;
		ar_p = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge i_mclk);
			if (!ar_p && rvalid === 1'b1) begin
				`CHK(rdata, {16'h0000, ed})
				`CHK(rresp, er)
				rready <= 1'b0;
				break;
			end
			if (ar_p && arready === 1'b1) begin
				ar_p = 1'b0;
				arvalid <= 1'b0;
			end
		end
		if (n == 60) begin
			bad_count++;
		end
		@(posedge i_mclk);
	endtask : rd_chk
	// Outputs trail their register by one edge; three leaves margin
	task automatic settle();
		repeat (3) @(posedge i_mclk);
	endtask : settle
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [1:0] OK = tx_link_admin_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = tx_link_admin_pkg::RESP_SLVERR;
	initial begin
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		settle();
		rd_chk(16'h0CCC, 16'h0000, OK);
		rd_chk(16'h0D14, 16'h0000, OK);
		rd_chk(16'h0D18, 16'hFFFF, OK);
		rd_chk(16'h1004, 16'h0000, OK);
		rd_chk(16'h1008, 16'h0000, OK);
		rd_chk(16'h100C, 16'h0C0C, OK);
		rd_chk(16'h1018, 16'h0C0C, OK);
		`CHK(integ_exp[7], 5'h14)
		`CHK(integ_exp4[3], 5'h14)
		`CHK(integ_exp4[4], 5'h00)
		$display("test reset values done");
		axi_wr(16'h0CCC, 16'h010B, OK);
		settle();
		`CHK(add_req, 1'b1)
		`CHK(add_grp, 3'h3)
		rd_chk(16'h0CCC, 16'h0000, OK);
		axi_wr(16'h0CCC, 16'h0105, OK);
		settle();
		`CHK(add_req, 1'b0)
		`CHK(add_grp, 3'h5)
		$display("test add link done");
		axi_wr(16'h0CD8, 16'hFFFF, OK);
		axi_wr(16'h0CF4, 16'h0A15, OK);
		settle();
		rd_chk(16'h0CD8, 16'h1F1F, OK);
		rd_chk(16'h0CF4, 16'h0A15, OK);
		`CHK(link_id[0], 5'h00)
		grp_mode <= 16'h8101;
		started <= 16'h010B;
		settle();
		`CHK(link_id[0], 5'h1F)
		`CHK(link_id[8], 5'h1F)
		`CHK(link_id[15], 5'h0A)
		`CHK(link_id[7], 5'h00)
		$display("test link id done");
		rd_chk(16'h0D14, 16'h0101, OK);
		rd_chk(16'h0D18, 16'h7EFE, OK);
		axi_wr(16'h0D14, 16'hFFFF, OK);
		axi_wr(16'h0D18, 16'h0000, OK);
		settle();
		rd_chk(16'h0D14, 16'h0101, OK);
		rd_chk(16'h0D18, 16'h7EFE, OK);
		grp_mode <= 16'h0000;
		settle();
		`CHK(add_grp, 3'h5)
		rd_chk(16'h0D14, 16'h0000, OK);
		rd_chk(16'h0D18, 16'hFFFF, OK);
		$display("test status done");
		axi_wr(16'h1004, 16'hFFA5, OK);
		axi_wr(16'h1008, 16'hA5C3, OK);
		settle();
		rd_chk(16'h1004, 16'h00A5, OK);
		rd_chk(16'h1008, 16'hA5C3, OK);
		`CHK(grp_user, 8'hA5)
		`CHK(lnk_user, 16'hA5C3)
		`CHK(grp_user4, 8'h05)
		$display("test count select done");
		axi_wr(16'h100C, 16'hFE31, OK);
		settle();
		rd_chk(16'h100C, 16'h0E31, OK);
		`CHK(integ_exp[0], 5'h09)
		`CHK(integ_exp[4], 5'h16)
		`CHK(integ_exp[1], 5'h14)
		// Reserved code must leave the running period alone
		axi_wr(16'h100C, 16'h0F0F, OK);
		settle();
		`CHK(integ_exp[0], 5'h09)
		`CHK(integ_exp[4], 5'h16)
		$display("test integration done");
		rd_chk(16'h0000, 16'h0000, ERR);
		axi_wr(16'h0D00, 16'hFFFF, ERR);
		rd_chk(16'h1008, 16'hA5C3, OK);
		axi_wr(16'h1008, 16'h0000, OK, 4'h1);
		rd_chk(16'h1008, 16'hA500, OK);
		$display("test unmapped done");
		results();
	end
	initial begin
		repeat (8000) @(posedge i_mclk);
		bad_count++;
		results();
	end
endmodule : tx_link_admin_regs_tb_top
`undef CHK
`default_nettype wire
